// File: buck_rail_defs.svh
// Offsets, field positions, reset values and timing for the buck rail register bank
`ifndef BUCK_RAIL_DEFS_SVH
`define BUCK_RAIL_DEFS_SVH
// Register indices as printed; byte address is four times the index
`define IDX_PAD0 32'h5000_0094
`define IDX_PAD1 32'h5000_0096
`define IDX_RET0 32'h5000_0098
`define IDX_RET1 32'h5000_009A
`define IDX_TRIM 32'h0500_009C
`define IDX_TST0 32'h5000_009E
`define IDX_TST1 32'h5000_00A0
`define RST_PAD0 16'hE3E4
`define RST_PAD1 16'hBC90
`define RST_RET0 16'hAAA6
`define RST_RET1 16'hAA46
`define RST_ZERO 16'h0000
`define MSK_FULL 16'hFFFF
`define MSK_TRIM 16'h3FFF
`define MSK_TST1 16'h1FF0
`define TOP_BIT 15
`define NEXT_BIT 14
`define LVL_MSB 14
`define LVL_LSB 10
`define MID_MSB 9
`define MID_LSB 5
`define LOW_MSB 4
`define LOW_LSB 0
`define MAXLV_MSB 13
`define MAXLV_LSB 10
`define CNT_HI_MSB 15
`define CNT_HI_LSB 13
`define LIM_HI_MSB 12
`define LIM_HI_LSB 8
`define CNT_LO_MSB 7
`define CNT_LO_LSB 5
`define PSEL_BIT 13
`define PCODE_MSB 12
`define PCODE_LSB 7
`define NSEL_BIT 6
`define NCODE_MSB 5
`define NCODE_LSB 0
`define MON_MSB 13
`define MON_LSB 11
`define PRB_MSB 10
`define PRB_LSB 8
`define FRC_MSB 7
`define FRC_LSB 0
`define CLKV_MSB 12
`define CLKV_LSB 9
`define TCUR_MSB 8
`define TCUR_LSB 4
`define ADAPT_RST 5'h04
`define IDLE_STEP_NS 125
`define CLK_PERIOD_NS 10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: buck_rail_pkg.sv
// Types shared by the buck rail register bank
package buck_rail_pkg;
  typedef struct packed {
    logic quick_ramp;
    logic [4:0] level;
    logic [4:0] high_batt_max_limit;
    logic [4:0] min_limit;
  } pad_cfg_s;
  typedef struct packed {
    logic [3:0][2:0] charge_count;
    logic [3:0][4:0] limit;
  } sleep_cfg_s;
  typedef struct packed {
    logic high_side_manual;
    logic [5:0] high_side_code;
    logic low_side_manual;
    logic [5:0] low_side_code;
  } trim_cfg_s;
  typedef enum logic [2:0] {
    ST_BUSY = 3'b001,
    ST_IDLE = 3'b010,
    ST_ADJ = 3'b100
  } adapt_state_e;
endpackage : buck_rail_pkg

// File: buck_rail_config_regs.sv
// Buck converter rail configuration bank with AXI4-Lite access and pad rail limit adaptation
// Notes on behaviour
// - Bit 15 selects quick current ramping, resets 1
// - High-battery maximum limit field, reset 0x1F
// - Minimum limit field, reset 0x4
// - Rail enables per battery mode, bits 15/14
// - Low-battery maximum limit field, reset 0xF
// - Idle beyond floor plus hysteresis lowers limit
// - Idle shorter than floor raises the limit
// - Sleep charge counts, three bits per rail
// - Sleep current limits, five bits per rail
// - High-side trim: automatic or manual select
// - High-side manual trim code, sign-magnitude
// - Low-side trim: automatic or manual select
// - Low-side manual trim code, sign-magnitude
// - Forced comparator clocks replace automatic ones
// - Forced current replaces the adaptive limit
// - Monitor select decodes one rail or none
// - Probe select decodes one source or none
// - Test bits force the switch outputs
// - Four forced comparator clock values
// - Test current value used when forced
//
// Register access over AXI4-Lite is this design's own decision.
`include "buck_rail_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module buck_rail_config_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic batt_low_pin,
  input wire logic conv_idle_pin,
  input wire logic [3:0] comp_clk_auto,
  input wire logic [5:0] high_side_trim_auto,
  input wire logic [5:0] low_side_trim_auto,
  output buck_rail_pkg::pad_cfg_s pad_cfg,
  output logic pad_rail_on,
  output logic [4:0] active_current_limit,
  output logic [3:0] comp_clk,
  output buck_rail_pkg::sleep_cfg_s sleep_cfg,
  output buck_rail_pkg::trim_cfg_s trim_cfg,
  output logic [3:0] adc_monitor_select,
  output logic [2:0] analog_probe_select,
  output logic [7:0] switch_force
);
  localparam int NREG = 7;
  localparam int STEP_CYC_I = (`IDLE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [3:0] STEP_CYC = 4'(STEP_CYC_I < 1 ? 1 : STEP_CYC_I);
  localparam logic [31:0] IDX [NREG] = '{`IDX_PAD0, `IDX_PAD1, `IDX_RET0, `IDX_RET1,
                                         `IDX_TRIM, `IDX_TST0, `IDX_TST1};
  localparam logic [15:0] RST [NREG] = '{`RST_PAD0, `RST_PAD1, `RST_RET0, `RST_RET1,
                                         `RST_ZERO, `RST_ZERO, `RST_ZERO};
  localparam logic [15:0] MSK [NREG] = '{`MSK_FULL, `MSK_FULL, `MSK_FULL, `MSK_FULL,
                                         `MSK_TRIM, `MSK_FULL, `MSK_TST1};

  logic [15:0] regs_r [NREG];
  logic aw_free_r;
  logic w_free_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [15:0] w_data_r;
  logic [1:0] w_be_r;

  // Write channel: address and data are taken independently and held
  wire aw_take = awvalid & aw_free_r;
  wire w_take = wvalid & w_free_r;
  wire do_write = ~aw_free_r & ~w_free_r & ~bvalid;
  wire b_done = bvalid & bready;
  wire ar_take = arvalid & arready;
  wire r_done = rvalid & rready;
  wire [15:0] be_mask = {{8{w_be_r[1]}}, {8{w_be_r[0]}}};

  logic [NREG-1:0] wr_hit;
  logic [NREG-1:0] rd_hit;
  logic [15:0] rd_terms [NREG];
  logic [15:0] rd_word;

  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_reg
      assign wr_hit[g] = aw_addr_r[ADDR_W-1:2] == IDX[g][ADDR_W-3:0];
      assign rd_hit[g] = araddr[ADDR_W-1:2] == IDX[g][ADDR_W-3:0];
      assign rd_terms[g] = rd_hit[g] ? (regs_r[g] & MSK[g]) : 16'h0000;
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          regs_r[g] <= RST[g];
        else if (do_write && wr_hit[g])
          regs_r[g] <= ((regs_r[g] & ~be_mask) | (w_data_r & be_mask)) & MSK[g];
      end
    end
  endgenerate

  always_comb
  begin
    rd_word = 16'h0000;
    for (int k = 0; k < NREG; k++)
      rd_word = rd_word | rd_terms[k];
  end

  wire wr_mapped = |wr_hit;
  wire rd_mapped = |rd_hit;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      aw_free_r <= 1'b1;
      w_free_r <= 1'b1;
      aw_addr_r <= '0;
      w_data_r <= 16'h0000;
      w_be_r <= 2'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_free_r <= 1'b0;
        aw_addr_r <= awaddr;
      end
      if (w_take)
      begin
        w_free_r <= 1'b0;
        w_data_r <= wdata[15:0];
        w_be_r <= wstrb[1:0];
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (b_done)
      begin
        bvalid <= 1'b0;
        aw_free_r <= 1'b1;
        w_free_r <= 1'b1;
      end
    end
  end

  assign awready = aw_free_r;
  assign wready = w_free_r;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_word};
      rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (r_done)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Field views
  wire [15:0] pad0 = regs_r[0];
  wire [15:0] pad1 = regs_r[1];
  wire [15:0] ret0 = regs_r[2];
  wire [15:0] ret1 = regs_r[3];
  wire [15:0] trim = regs_r[4];
  wire [15:0] tst0 = regs_r[5];
  wire [15:0] tst1 = regs_r[6];
  wire quick_ramp = pad0[`TOP_BIT];
  wire [4:0] max_hv = pad0[`MID_MSB:`MID_LSB];
  wire [4:0] min_lim = pad0[`LOW_MSB:`LOW_LSB];
  wire [4:0] max_lv = {1'b0, pad1[`MAXLV_MSB:`MAXLV_LSB]};
  wire [4:0] hyst = pad1[`MID_MSB:`MID_LSB];
  wire [4:0] floor_t = pad1[`LOW_MSB:`LOW_LSB];
  wire force_clk = tst0[`TOP_BIT];
  wire force_cur = tst0[`NEXT_BIT];
  wire [2:0] mon = tst0[`MON_MSB:`MON_LSB];
  wire [2:0] prb = tst0[`PRB_MSB:`PRB_LSB];
  wire [3:0] clk_vals = tst1[`CLKV_MSB:`CLKV_LSB];
  wire [4:0] test_cur = tst1[`TCUR_MSB:`TCUR_LSB];

  // Configuration outputs come straight from the register flops
  assign pad_cfg.quick_ramp = quick_ramp;
  assign pad_cfg.level = pad0[`LVL_MSB:`LVL_LSB];
  assign pad_cfg.high_batt_max_limit = max_hv;
  assign pad_cfg.min_limit = min_lim;
  // Order of rails: 3 pad, 2 core, 1 main 1.8 V, 0 rail 1.4 V
  assign sleep_cfg.charge_count = {ret0[`CNT_HI_MSB:`CNT_HI_LSB], ret0[`CNT_LO_MSB:`CNT_LO_LSB],
                                   ret1[`CNT_HI_MSB:`CNT_HI_LSB], ret1[`CNT_LO_MSB:`CNT_LO_LSB]};
  assign sleep_cfg.limit = {ret0[`LIM_HI_MSB:`LIM_HI_LSB], ret0[`LOW_MSB:`LOW_LSB],
                            ret1[`LIM_HI_MSB:`LIM_HI_LSB], ret1[`LOW_MSB:`LOW_LSB]};

  // Pins from the analog side: three flops, value moves once stages two and three agree
  logic [1:0] sy1_r;
  logic [1:0] sy2_r;
  logic [1:0] sy3_r;
  logic [1:0] pin_r;
  wire [1:0] pin_nxt = (sy2_r & sy3_r) | (pin_r & (sy2_r ^ sy3_r));
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sy1_r <= 2'h0;
      sy2_r <= 2'h0;
      sy3_r <= 2'h0;
      pin_r <= 2'h0;
    end
    else
    begin
      sy1_r <= {batt_low_pin, conv_idle_pin};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= pin_nxt;
    end
  end
  wire batt_low = pin_r[1];
  wire idle_now = pin_r[0];

  // Idle-time measurement in 130 ns ticks (125 ns rounded up to 13 cycles of 10 ns), saturating
  buck_rail_pkg::adapt_state_e st_r;
  buck_rail_pkg::adapt_state_e st_nxt;
  logic [3:0] div_r;
  logic [5:0] ticks_r;
  logic [4:0] adapt_r;
  wire tick = div_r == STEP_CYC - 4'h1;
  wire [5:0] idle_max = {1'b0, floor_t} + {1'b0, hyst};
  wire [4:0] hi_lim = batt_low ? max_lv : max_hv;
  wire too_short = ticks_r < {1'b0, floor_t};
  wire too_long = ticks_r > idle_max;
  wire [5:0] step = quick_ramp ? 6'h02 : 6'h01;
  wire [5:0] up_val = {1'b0, adapt_r} + step;
  wire [5:0] dn_val = ({1'b0, adapt_r} > step) ? {1'b0, adapt_r} - step : 6'h00;
  wire [5:0] raw = (st_r == buck_rail_pkg::ST_ADJ && too_short) ? up_val :
                   (st_r == buck_rail_pkg::ST_ADJ && too_long) ? dn_val : {1'b0, adapt_r};
  // Upper bound wins if software sets minimum above maximum
  wire [5:0] lo_clamp = raw < {1'b0, min_lim} ? {1'b0, min_lim} : raw;
  wire [4:0] adapt_nxt = lo_clamp > {1'b0, hi_lim} ? hi_lim : lo_clamp[4:0];

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      buck_rail_pkg::ST_BUSY: if (idle_now) st_nxt = buck_rail_pkg::ST_IDLE;
      buck_rail_pkg::ST_IDLE: if (!idle_now) st_nxt = buck_rail_pkg::ST_ADJ;
      buck_rail_pkg::ST_ADJ: st_nxt = buck_rail_pkg::ST_BUSY;
      default: st_nxt = buck_rail_pkg::ST_BUSY;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r <= buck_rail_pkg::ST_BUSY;
      div_r <= 4'h0;
      ticks_r <= 6'h00;
      adapt_r <= `ADAPT_RST;
    end
    else
    begin
      st_r <= st_nxt;
      adapt_r <= adapt_nxt;
      if (st_r != buck_rail_pkg::ST_IDLE)
      begin
        div_r <= 4'h0;
        if (st_r == buck_rail_pkg::ST_BUSY)
          ticks_r <= 6'h00;
      end
      else
      begin
        div_r <= tick ? 4'h0 : div_r + 4'h1;
        if (tick && ticks_r != 6'h3F)
          ticks_r <= ticks_r + 6'h01;
      end
    end
  end

  // Effective outputs, registered
  wire [3:0] mon_dec = (mon == 3'h1) ? 4'h1 : (mon == 3'h2) ? 4'h2 :
                       (mon == 3'h3) ? 4'h4 : (mon == 3'h4) ? 4'h8 : 4'h0;
  wire [2:0] prb_dec = (prb == 3'h1) ? 3'h1 : (prb == 3'h2) ? 3'h2 :
                       (prb == 3'h3) ? 3'h4 : 3'h0;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pad_rail_on <= 1'b0;
      active_current_limit <= `ADAPT_RST;
      comp_clk <= 4'h0;
      trim_cfg <= '0;
      adc_monitor_select <= 4'h0;
      analog_probe_select <= 3'h0;
      switch_force <= 8'h00;
    end
    else
    begin
      pad_rail_on <= batt_low ? pad1[`NEXT_BIT] : pad1[`TOP_BIT];
      active_current_limit <= force_cur ? test_cur : adapt_r;
      comp_clk <= force_clk ? clk_vals : comp_clk_auto;
      trim_cfg.high_side_manual <= trim[`PSEL_BIT];
      trim_cfg.high_side_code <= trim[`PSEL_BIT] ? trim[`PCODE_MSB:`PCODE_LSB] : high_side_trim_auto;
      trim_cfg.low_side_manual <= trim[`NSEL_BIT];
      trim_cfg.low_side_code <= trim[`NSEL_BIT] ? trim[`NCODE_MSB:`NCODE_LSB] : low_side_trim_auto;
      adc_monitor_select <= mon_dec;
      analog_probe_select <= prb_dec;
      switch_force <= tst0[`FRC_MSB:`FRC_LSB];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_write_answer: assert property (do_write |=> bvalid) else $error("write not answered");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  a_read_answer: assert property (ar_take |=> rvalid && !arready) else $error("read not answered");
  a_reset_pad: assert property (
    $past(!rst_n) |-> regs_r[0] == `RST_PAD0 && regs_r[3] == `RST_RET1)
    else $error("reset value wrong");
  a_force_current: assert property (
    force_cur |=> active_current_limit == $past(test_cur))
    else $error("forced current ignored");
  a_adaptive_current: assert property (
    !force_cur |=> active_current_limit == $past(adapt_r))
    else $error("adaptive limit not applied");
  a_force_clock: assert property (
    force_clk |=> comp_clk == $past(clk_vals))
    else $error("forced clocks ignored");
  a_limit_clamp: assert property (
    min_lim <= hi_lim |=> adapt_r <= $past(hi_lim) && adapt_r >= $past(min_lim))
    else $error("limit out of bounds");
  a_raise_short: assert property (
    st_r == buck_rail_pkg::ST_ADJ && too_short && adapt_r >= min_lim
    && {1'b0, adapt_r} + step <= {1'b0, hi_lim} |=> adapt_r == $past(up_val[4:0]))
    else $error("short idle did not raise");
  // Sum kept six bits wide so a minimum near the top cannot wrap
  a_lower_long: assert property (
    st_r == buck_rail_pkg::ST_ADJ && too_long && adapt_r <= hi_lim
    && {1'b0, adapt_r} >= {1'b0, min_lim} + step |=> adapt_r < $past(adapt_r))
    else $error("long idle did not lower");
  a_monitor_pa: assert property (
    mon == 3'h4 |=> adc_monitor_select == 4'h8)
    else $error("monitor decode wrong");
  a_probe_buffer: assert property (
    prb == 3'h3 |=> analog_probe_select == 3'h4)
    else $error("probe decode wrong");
  // Starts only outside reset: the flop holds zero through the reset edge
  a_rail_enable: assert property (
    rst_n |=> pad_rail_on == $past(batt_low ? pad1[14] : pad1[15]))
    else $error("rail enable wrong");

  c_write_done: cover property (do_write ##1 b_done);
  c_read_done: cover property (ar_take ##[1:4] r_done);
  c_raise: cover property (st_r == buck_rail_pkg::ST_ADJ && too_short);
  c_lower: cover property (st_r == buck_rail_pkg::ST_ADJ && too_long);
  c_forced: cover property (force_cur && force_clk);
endmodule : buck_rail_config_regs
`default_nettype wire

// File: buck_rail_config_regs_tb_top.sv
// Self-checking bench for the buck rail configuration bank
`include "buck_rail_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module buck_rail_config_regs_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic batt_low_pin = 1'b0;
  logic conv_idle_pin = 1'b0;
  logic [3:0] comp_clk_auto = 4'h5;
  logic [5:0] high_side_trim_auto = 6'h2A;
  logic [5:0] low_side_trim_auto = 6'h15;
  buck_rail_pkg::pad_cfg_s pad_cfg;
  logic pad_rail_on;
  logic [4:0] active_current_limit;
  logic [3:0] comp_clk;
  buck_rail_pkg::sleep_cfg_s sleep_cfg;
  buck_rail_pkg::trim_cfg_s trim_cfg;
  logic [3:0] adc_monitor_select;
  logic [2:0] analog_probe_select;
  logic [7:0] switch_force;
  int mismatches = 0;
  int total_checks = 0;
  logic [11:0] addr_tab [7] = '{12'h250, 12'h258, 12'h260, 12'h268, 12'h270, 12'h278, 12'h280};
  logic [15:0] rst_tab [7] = '{`RST_PAD0, `RST_PAD1, `RST_RET0, `RST_RET1, `RST_ZERO, `RST_ZERO, `RST_ZERO};
  logic [15:0] msk_tab [7] = '{`MSK_FULL, `MSK_FULL, `MSK_FULL, `MSK_FULL, `MSK_TRIM, `MSK_FULL, `MSK_TST1};

  always #5 clock = ~clock;

  buck_rail_config_regs #(.ADDR_W(12)) u_buck_rail_config_regs (.clock(clock), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .batt_low_pin(batt_low_pin), .conv_idle_pin(conv_idle_pin), .comp_clk_auto(comp_clk_auto),
    .high_side_trim_auto(high_side_trim_auto), .low_side_trim_auto(low_side_trim_auto), .pad_cfg(pad_cfg),
    .pad_rail_on(pad_rail_on), .active_current_limit(active_current_limit), .comp_clk(comp_clk),
    .sleep_cfg(sleep_cfg), .trim_cfg(trim_cfg), .adc_monitor_select(adc_monitor_select),
    .analog_probe_select(analog_probe_select), .switch_force(switch_force));

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data go out together; each is dropped at its own handshake edge
  task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] resp);
    resp = 2'bxx;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No local limit: only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clock);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        resp = bresp;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    d = 32'hxxxx_xxxx;
    resp = 2'bxx;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        resp = rresp;
      end
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
    chk(r, `RESP_OKAY);
    repeat (3) @(posedge clock);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(r, `RESP_OKAY);
    chk(d, {16'h0000, exp});
  endtask : rd

  task automatic idle_pulse(input int len);
    @(posedge clock);
    conv_idle_pin <= 1'b1;
    repeat (len) @(posedge clock);
    conv_idle_pin <= 1'b0;
    repeat (30) @(posedge clock);
  endtask : idle_pulse

  task automatic t_reset;
    for (int i = 0; i < 7; i++)
      rd(addr_tab[i], rst_tab[i]);
    chk(pad_cfg, `RST_PAD0);
    chk({sleep_cfg.charge_count[3], sleep_cfg.charge_count[0]}, 32'h0000_002A);
    chk({sleep_cfg.limit[3], sleep_cfg.limit[2]}, 32'h0000_0146);
    chk(active_current_limit, 32'h0000_0004);
    chk(pad_rail_on, 32'h0000_0001);
  endtask : t_reset

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(12'h254, 16'hFFFF, 4'hF, r);
    chk(r, `RESP_SLVERR);
    axi_rd(12'h254, d, r);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h0000_0000);
  endtask : t_unmapped

  // Short idle raises the limit, long idle lowers it, both ends clamp
  task automatic t_adapt;
    idle_pulse(20);
    chk(active_current_limit, 32'h0000_0006);
    idle_pulse(400);
    chk(active_current_limit, 32'h0000_0004);
    idle_pulse(400);
    chk(active_current_limit, 32'h0000_0004);
    wr(12'h250, 16'hE0A4);
    idle_pulse(20);
    chk(active_current_limit, 32'h0000_0005);
    batt_low_pin <= 1'b1;
    repeat (10) @(posedge clock);
    idle_pulse(20);
    chk(active_current_limit, 32'h0000_0007);
    batt_low_pin <= 1'b0;
    repeat (10) @(posedge clock);
    wr(12'h250, 16'h63E4);
    idle_pulse(20);
    chk(active_current_limit, 32'h0000_0006);
    wr(12'h250, `RST_PAD0);
  endtask : t_adapt

  task automatic t_batt;
    batt_low_pin <= 1'b1;
    repeat (10) @(posedge clock);
    chk(pad_rail_on, 32'h0000_0000);
    wr(12'h258, 16'hFC90);
    chk(pad_rail_on, 32'h0000_0001);
    batt_low_pin <= 1'b0;
    wr(12'h258, 16'h3C90);
    chk(pad_rail_on, 32'h0000_0000);
    wr(12'h258, `RST_PAD1);
  endtask : t_batt

  task automatic t_trim;
    chk(trim_cfg, 32'h0000_1515);
    wr(12'h270, 16'h2FFF);
    chk(trim_cfg, 32'h0000_2FFF);
    wr(12'h270, 16'h3000);
    chk(trim_cfg, 32'h0000_3015);
    wr(12'h270, `RST_ZERO);
  endtask : t_trim

  task automatic t_test;
    for (int c = 0; c < 8; c++)
    begin
      wr(12'h278, 16'((c << 11) | (c << 8)));
      chk(adc_monitor_select, (c >= 1 && c <= 4) ? (32'h1 << (c - 1)) : 32'h0);
      chk(analog_probe_select, (c >= 1 && c <= 3) ? (32'h1 << (c - 1)) : 32'h0);
    end
    wr(12'h278, 16'h00A5);
    chk(switch_force, 32'h0000_00A5);
    wr(12'h278, 16'h005A);
    chk(switch_force, 32'h0000_005A);
    wr(12'h280, 16'h1490);
    wr(12'h278, 16'hC000);
    chk(comp_clk, 32'h0000_000A);
    chk(active_current_limit, 32'h0000_0009);
    wr(12'h278, `RST_ZERO);
    comp_clk_auto <= 4'h9;
    repeat (3) @(posedge clock);
    chk(comp_clk, 32'h0000_0009);
    // Adaptive limit was left at six by the last single-step raise
    chk(active_current_limit, 32'h0000_0006);
  endtask : t_test

  task automatic t_rw;
    logic [15:0] pat [2];
    logic [1:0] r;
    pat = '{16'hA5A5, 16'h5A5A};
    for (int i = 0; i < 7; i++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        wr(addr_tab[i], pat[p]);
        rd(addr_tab[i], pat[p] & msk_tab[i]);
      end
      wr(addr_tab[i], rst_tab[i]);
    end
    axi_wr(12'h250, 16'h0000, 4'h1, r);
    rd(12'h250, 16'hE300);
    axi_wr(12'h250, 16'h1B00, 4'h2, r);
    repeat (3) @(posedge clock);
    chk(pad_cfg, 32'h0000_1B00);
    rd(12'h250, 16'h1B00);
  endtask : t_rw

  initial
  begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_unmapped;
    t_adapt;
    t_batt;
    t_trim;
    t_test;
    t_rw;
    summarize;
  end

  // Whole run needs under two thousand cycles; this allows twenty thousand
  initial
  begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule : buck_rail_config_regs_tb_top
`default_nettype wire
